//--- src/psm_glitch_filter.sv
// comparator glitch filter: a low must persist before it counts
`timescale 1ns/100ps
`default_nettype none

module psm_glitch_filter
	import psm_pkg::*;
(
	input  wire logic  clk_sys_i,
	input  wire logic  rstn_i,
	input  wire logic  ce_i,
	input  wire logic  monitor_enable_i,
	input  wire logic  digital_supply_good_i,
	input  wire logic  analog_supply_good_i,
	psm_sup_if.filt    sup
);

	logic [PSM_FILT_W-1:0] cnt_d;
	logic [PSM_FILT_W-1:0] cnt_a;
	logic [PSM_FILT_W-1:0] next_cnt_d;
	logic [PSM_FILT_W-1:0] next_cnt_a;
	logic                  next_low;

	// ------------------------------------------------------------
	// low-run counters
	// ------------------------------------------------------------
	always_comb
	begin
		next_cnt_d = '0;
		next_cnt_a = '0;
		if (monitor_enable_i && !digital_supply_good_i)
			next_cnt_d = psm_sat_inc(cnt_d, PSM_GLITCH_LIM);
		if (monitor_enable_i && !analog_supply_good_i)
			next_cnt_a = psm_sat_inc(cnt_a, PSM_GLITCH_LIM);
		next_low = (next_cnt_d == PSM_GLITCH_LIM) ||
			(next_cnt_a == PSM_GLITCH_LIM);
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_d          <= '0;
			cnt_a          <= '0;
			sup.supply_low <= 1'b0;
		end
		else if (ce_i)
		begin
			cnt_d          <= next_cnt_d;
			cnt_a          <= next_cnt_a;
			sup.supply_low <= next_low;
		end
	end

endmodule

`default_nettype wire

//--- src/psm_pkg.sv
// constants and types shared by the supply monitor design
//
// Operation
// - enabled monitor compares digital supply to threshold
// - one 8-bit control register, DFH, reset DEH
// - bit 6 mirrors live digital comparator
// - either comparator low sets flag bit 5
// - good supplies start 250 ms clearing timer
// - flag held until supplies good full timeout
// - software clear ignored while comparator low
// - flag raises interrupt when source enabled
// - short comparator dips are filtered out
// - bits 4:3 select digital trip point
// - bit 0 enables or disables monitor
`default_nettype none

package psm_pkg;

	// ------------------------------------------------------------
	// control register map
	// ------------------------------------------------------------
	localparam logic [7:0] PSM_CTRL_ADDR  = 8'hDF;
	localparam logic [7:0] PSM_CTRL_RESET = 8'hDE;
	localparam logic [7:0] PSM_RSVD_MASK  = 8'h86;
	localparam int         PSM_BIT_DGOOD  = 6;
	localparam int         PSM_BIT_FLAG   = 5;
	localparam int         PSM_BIT_TRIPHI = 4;
	localparam int         PSM_BIT_TRIPLO = 3;
	localparam int         PSM_BIT_EN     = 0;
	localparam logic [1:0] PSM_TRIP_RESET = 2'h3;
	localparam logic [1:0] PSM_TRIP_308   = 2'h1;
	localparam logic [1:0] PSM_TRIP_293   = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned PSM_CLK_HZ      = 40000000;
	localparam int unsigned PSM_CLK_MHZ     = 40;
	localparam int unsigned PSM_TIMEOUT_MS  = 250;
	localparam int unsigned PSM_TIMEOUT_CYC =
		(PSM_CLK_HZ / 1000) * PSM_TIMEOUT_MS;
	localparam int unsigned PSM_GLITCH_NS   = 1000;
	localparam int unsigned PSM_GLITCH_CYC  =
		(PSM_GLITCH_NS * PSM_CLK_MHZ + 999) / 1000;
	localparam int          PSM_TMR_W       = 24;
	localparam int          PSM_FILT_W      = 6;
	localparam logic [PSM_FILT_W-1:0] PSM_GLITCH_LIM =
		PSM_FILT_W'(PSM_GLITCH_CYC);

	// ------------------------------------------------------------
	// types and helpers
	// ------------------------------------------------------------
	typedef enum logic [0:0]
	{
		PSM_TMR_IDLE = 1'b0,
		PSM_TMR_RUN  = 1'b1
	} psm_tmr_state_t;

	function automatic logic [PSM_FILT_W-1:0] psm_sat_inc
	(
		input logic [PSM_FILT_W-1:0] cnt,
		input logic [PSM_FILT_W-1:0] lim
	);
		psm_sat_inc = (cnt >= lim) ? lim : PSM_FILT_W'(cnt + 1'b1);
	endfunction

endpackage

`default_nettype wire

//--- src/psm_sup_if.sv
// interface between the monitor core, glitch filter and timeout timer
`timescale 1ns/100ps
`default_nettype none

interface psm_sup_if;
	logic supply_low;
	logic timer_run;
	logic timer_expire;

	modport filt (output supply_low);
	modport tmr  (input timer_run, output timer_expire);
	modport core (input supply_low, input timer_expire, output timer_run);
endinterface

`default_nettype wire

//--- src/psm_supply_monitor.sv
// supply monitor core: control register, low-supply flag, interrupt
`timescale 1ns/100ps
`default_nettype none

module psm_supply_monitor
	import psm_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = PSM_TIMEOUT_CYC
)
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_wr_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        digital_supply_good_i,
	input  wire logic        analog_supply_good_i,
	input  wire logic        secondary_irq_enable_i,
	output logic      [1:0]  trip_select_o,
	output logic             monitor_enable_o,
	output logic             low_supply_flag_o,
	output logic             low_supply_irq_o
);

	psm_sup_if sup ();

	logic [1:0] trip_select;
	logic       monitor_enable;
	logic       low_supply_flag;
	logic [7:0] rdata;
	logic       irq;
	logic [1:0] next_trip_select;
	logic       next_monitor_enable;
	logic       next_low_supply_flag;
	logic [7:0] next_rdata;
	logic       next_irq;
	logic       ctrl_wr;
	logic       raw_low;

	// ------------------------------------------------------------
	// filter and timer
	// ------------------------------------------------------------
	psm_glitch_filter u_filter
	(
		.clk_sys_i             (clk_sys_i),
		.rstn_i                (rstn_i),
		.ce_i                  (ce_i),
		.monitor_enable_i      (monitor_enable),
		.digital_supply_good_i (digital_supply_good_i),
		.analog_supply_good_i  (analog_supply_good_i),
		.sup                   (sup.filt)
	);

	psm_timeout #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_timeout
	(
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.sup       (sup.tmr)
	);

	// raw comparator low: abandons the timer and blocks a clear at once
	assign raw_low = monitor_enable
		&& !(digital_supply_good_i && analog_supply_good_i);

	// timer runs only while flag is up and supplies are good
	assign sup.timer_run = low_supply_flag && !sup.supply_low
		&& !raw_low;

	// ------------------------------------------------------------
	// register and flag next state
	// ------------------------------------------------------------
	always_comb
	begin
		ctrl_wr              = 1'b0;
		next_trip_select     = trip_select;
		next_monitor_enable  = monitor_enable;
		next_low_supply_flag = low_supply_flag;
		if (sfr_wr_i && (sfr_addr_i == PSM_CTRL_ADDR))
			ctrl_wr = 1'b1;
		if (ctrl_wr)
		begin
			next_trip_select = {sfr_wdata_i[PSM_BIT_TRIPHI],
				sfr_wdata_i[PSM_BIT_TRIPLO]};
			next_monitor_enable = sfr_wdata_i[PSM_BIT_EN];
		end
		// priority: hardware set, then software write, then timer clear
		if (sup.timer_expire)
			next_low_supply_flag = 1'b0;
		if (ctrl_wr)
		begin
			if (sfr_wdata_i[PSM_BIT_FLAG])
				next_low_supply_flag = 1'b1;
			else if (!sup.supply_low && !raw_low)
				next_low_supply_flag = 1'b0;
		end
		if (sup.supply_low)
			next_low_supply_flag = 1'b1;

		next_rdata = PSM_CTRL_RESET & PSM_RSVD_MASK;
		next_rdata[PSM_BIT_DGOOD]  = digital_supply_good_i;
		next_rdata[PSM_BIT_FLAG]   = low_supply_flag;
		next_rdata[PSM_BIT_TRIPHI] = trip_select[1];
		next_rdata[PSM_BIT_TRIPLO] = trip_select[0];
		next_rdata[PSM_BIT_EN]     = monitor_enable;

		next_irq = low_supply_flag && secondary_irq_enable_i;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			trip_select     <= PSM_TRIP_RESET;
			monitor_enable  <= PSM_CTRL_RESET[PSM_BIT_EN];
			low_supply_flag <= PSM_CTRL_RESET[PSM_BIT_FLAG];
			rdata           <= PSM_CTRL_RESET;
			irq             <= 1'b0;
		end
		else if (ce_i)
		begin
			trip_select     <= next_trip_select;
			monitor_enable  <= next_monitor_enable;
			low_supply_flag <= next_low_supply_flag;
			rdata           <= next_rdata;
			irq             <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata_o       = rdata;
	assign trip_select_o     = trip_select;
	assign monitor_enable_o  = monitor_enable;
	assign low_supply_flag_o = low_supply_flag;
	assign low_supply_irq_o  = irq;

endmodule

`default_nettype wire

//--- src/psm_timeout.sv
// good-supply timeout timer that clears the low-supply flag
`timescale 1ns/100ps
`default_nettype none

module psm_timeout
	import psm_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = PSM_TIMEOUT_CYC
)
(
	input  wire logic  clk_sys_i,
	input  wire logic  rstn_i,
	input  wire logic  ce_i,
	psm_sup_if.tmr     sup
);

	localparam logic [PSM_TMR_W-1:0] LAST =
		PSM_TMR_W'(TIMEOUT_CYCLES - 1);

	psm_tmr_state_t        state;
	psm_tmr_state_t        next_state;
	logic [PSM_TMR_W-1:0]  cnt;
	logic [PSM_TMR_W-1:0]  next_cnt;
	logic                  next_expire;

	// ------------------------------------------------------------
	// timer state machine
	// ------------------------------------------------------------
	always_comb
	begin
		next_state  = state;
		next_cnt    = cnt;
		next_expire = 1'b0;
		case (state)
			PSM_TMR_IDLE:
			begin
				next_cnt = '0;
				if (sup.timer_run)
					next_state = PSM_TMR_RUN;
			end
			PSM_TMR_RUN:
			begin
				if (!sup.timer_run)
				begin
					next_state = PSM_TMR_IDLE;
					next_cnt   = '0;
				end
				else if (cnt == LAST)
				begin
					next_state  = PSM_TMR_IDLE;
					next_cnt    = '0;
					next_expire = 1'b1;
				end
				else
					next_cnt = PSM_TMR_W'(cnt + 1'b1);
			end
			default:
			begin
				next_state = PSM_TMR_IDLE;
				next_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state            <= PSM_TMR_IDLE;
			cnt              <= '0;
			sup.timer_expire <= 1'b0;
		end
		else if (ce_i)
		begin
			state            <= next_state;
			cnt              <= next_cnt;
			sup.timer_expire <= next_expire;
		end
	end

endmodule

`default_nettype wire

//--- verification/psm_comparator_model.sv
// behavioural analog supply comparators
`timescale 1ns/100ps
`default_nettype none

module psm_comparator_model
	import psm_pkg::*;
(
	input  wire logic [15:0] digital_mv_i,
	input  wire logic [15:0] analog_mv_i,
	input  wire logic [1:0]  trip_select_i,
	output logic             digital_supply_good_o,
	output logic             analog_supply_good_o
);
	always_comb
	begin
		digital_supply_good_o = 1'b1;
		if (trip_select_i == PSM_TRIP_308)
			digital_supply_good_o = digital_mv_i >= 16'h0C08;
		if (trip_select_i == PSM_TRIP_293)
			digital_supply_good_o = digital_mv_i >= 16'h0B72;
		analog_supply_good_o = analog_mv_i >= 16'h0A8C;
	end
endmodule

`default_nettype wire

//--- verification/psm_supply_monitor_assertions.sv
// port-level assertions for the supply monitor
`timescale 1ns/100ps
`default_nettype none

module psm_supply_monitor_assertions
	import psm_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = PSM_TIMEOUT_CYC
)
(
	input wire logic       clk_sys_i,
	input wire logic       rstn_i,
	input wire logic       ce_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       digital_supply_good_i,
	input wire logic       analog_supply_good_i,
	input wire logic       secondary_irq_enable_i,
	input wire logic [1:0] trip_select_o,
	input wire logic       monitor_enable_o,
	input wire logic       low_supply_flag_o,
	input wire logic       low_supply_irq_o
);
	logic [7:0] low_cnt;
	logic [31:0] good_cnt;
	logic       is_low;
	logic       wr_ctl;
	logic       wr_clr;
	logic       wr_set;
	logic       irq_src;

	assign is_low  = monitor_enable_o
		& ~(digital_supply_good_i & analog_supply_good_i);
	assign wr_ctl  = ce_i & sfr_wr_i & (sfr_addr_i == PSM_CTRL_ADDR);
	assign wr_clr  = wr_ctl & ~sfr_wdata_i[5];
	assign wr_set  = wr_ctl & sfr_wdata_i[5];
	assign irq_src = low_supply_flag_o & secondary_irq_enable_i;

	// ------------
	// run lengths of low and good supply
	// ------------
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			low_cnt  <= 8'h00;
			good_cnt <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			low_cnt  <= is_low ? low_cnt + 8'(low_cnt != 8'hFF) : 8'h00;
			good_cnt <= is_low ? 32'h0000_0000
				: good_cnt + 32'(good_cnt != 32'hFFFF_FFFF);
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	sequence s_long_low;
		low_cnt >= 8'h2B;
	endsequence
	sequence s_timed_out;
		good_cnt == TIMEOUT_CYCLES + 32'h6;
	endsequence
	property p_irq;
		ce_i |=> low_supply_irq_o == $past(irq_src);
	endproperty
	property p_dgood;
		ce_i |=> sfr_rdata_o[6] == $past(digital_supply_good_i);
	endproperty
	property p_rsvd;
		(sfr_rdata_o & PSM_RSVD_MASK) == PSM_RSVD_MASK;
	endproperty
	property p_write;
		wr_ctl |=> trip_select_o == $past(sfr_wdata_i[4:3])
			&& monitor_enable_o == $past(sfr_wdata_i[0]);
	endproperty
	property p_set;
		s_long_low |-> low_supply_flag_o;
	endproperty
	property p_glitch;
		$rose(low_supply_flag_o) |-> $past(low_cnt, 2) >= 8'h1E
			|| $past(wr_set);
	endproperty
	property p_blocked;
		(wr_clr and s_long_low) |=> low_supply_flag_o;
	endproperty
	property p_hold;
		$fell(low_supply_flag_o) && !$past(wr_clr)
			|-> $past(good_cnt) >= TIMEOUT_CYCLES;
	endproperty
	property p_expire;
		s_timed_out |-> !low_supply_flag_o;
	endproperty

	a_irq: assert property (p_irq) else $error("irq mismatch");
	a_dgood: assert property (p_dgood) else $error("bit 6 stale");
	a_rsvd: assert property (p_rsvd) else $error("reserved bits");
	a_write: assert property (p_write) else $error("write lost");
	a_set: assert property (p_set) else $error("flag not set");
	a_glitch: assert property (p_glitch) else $error("dip set flag");
	a_blocked: assert property (p_blocked) else $error("clear taken");
	a_hold: assert property (p_hold) else $error("early clear");
	a_expire: assert property (p_expire) else $error("no timeout");
endmodule

bind psm_supply_monitor psm_supply_monitor_assertions
	#(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk
(
	.clk_sys_i, .rstn_i, .ce_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
	.sfr_rdata_o, .digital_supply_good_i, .analog_supply_good_i,
	.secondary_irq_enable_i, .trip_select_o, .monitor_enable_o,
	.low_supply_flag_o, .low_supply_irq_o
);

`default_nettype wire

//--- verification/psm_supply_monitor_tb.sv
// self-checking bench for the supply monitor
`timescale 1ns/100ps
`default_nettype none

module psm_supply_monitor_tb
	import psm_pkg::*;
;
	localparam int unsigned TMO = 20;
	logic        clk_sys_i   = 1'b0;
	logic        rstn_i      = 1'b0;
	logic [7:0]  sfr_addr_i  = 8'h00;
	logic [7:0]  sfr_wdata_i = 8'h00;
	logic        sfr_wr_i    = 1'b0;
	logic        irq_en      = 1'b0;
	logic        ce          = 1'b1;
	logic [15:0] dmv         = 16'h0D00;
	logic [15:0] amv         = 16'h0D00;
	logic [15:0] lfsr        = 16'h8402;
	logic [15:0] mvs [3]     = '{16'h0BB8, 16'h0C1C, 16'h0B54};
	logic [7:0]  rdata, d;
	logic [1:0]  trip, tp;
	logic        en, flag, irq, dg, ag;
	int          errors      = 0;
	int          cmp_count   = 0;

	psm_supply_monitor #(.TIMEOUT_CYCLES(TMO)) i_dut
	(
		.clk_sys_i, .rstn_i, .ce_i(ce), .sfr_addr_i, .sfr_wdata_i,
		.sfr_wr_i, .sfr_rdata_o(rdata), .digital_supply_good_i(dg),
		.analog_supply_good_i(ag), .secondary_irq_enable_i(irq_en),
		.trip_select_o(trip), .monitor_enable_o(en),
		.low_supply_flag_o(flag), .low_supply_irq_o(irq)
	);
	psm_comparator_model i_cmp
	(
		.digital_mv_i(dmv), .analog_mv_i(amv), .trip_select_i(trip),
		.digital_supply_good_o(dg), .analog_supply_good_o(ag)
	);

	// ------------
	// helpers
	// ------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction
	function automatic logic exp_dg(logic [15:0] mv, logic [1:0] t);
		if (t == PSM_TRIP_308)
			return mv >= 16'h0C08;
		if (t == PSM_TRIP_293)
			return mv >= 16'h0B72;
		return 1'b1;
	endfunction
	function automatic logic [7:0] exp_img(logic [1:0] t, logic e, f, g);
		return PSM_RSVD_MASK | {1'b0, g, f, t, 2'b00, e};
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		sfr_addr_i  = a;
		sfr_wdata_i = v;
		sfr_wr_i    = 1'b1;
		tick(1);
		sfr_wr_i = 1'b0;
		tick(2);
	endtask
	// analog supply below its level for n cycles
	task automatic low_run(int n);
		amv = 16'h0A00;
		tick(n);
		amv = 16'h0D00;
	endtask
	task give_verdict;
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------
	// clock, watchdog, tests
	// ------------
	initial
	begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		#500000;
		errors++;
		give_verdict();
	end
	initial
	begin
		tick(16);
		chk("reset image", rdata, PSM_CTRL_RESET);
		chk("reset outputs", {3'h0, trip, en, flag, irq}, 8'h18);
		rstn_i = 1'b1;
		tick(2);
		chk("live image", rdata, exp_img(2'h3, 1'b0, 1'b0, 1'b1));
		repeat (12)
		begin
			d = rnd() & 8'hDF;
			wr(PSM_CTRL_ADDR, d);
			wr(rnd() & 8'hDE, ~d);
			chk("outputs", {5'h00, trip, en}, {5'h00, d[4:3], d[0]});
			chk("image", rdata, exp_img(d[4:3], d[0], 1'b0, 1'b1));
		end
		foreach (mvs[i])
			for (int t = 1; t < 3; t++)
			begin
				tp  = 2'(t);
				dmv = mvs[i];
				wr(PSM_CTRL_ADDR, {3'h0, tp, 3'h1});
				chk("trip", rdata, exp_img(tp, 1'b1, 1'b0, exp_dg(dmv, tp)));
			end
		dmv = 16'h0D00;
		wr(PSM_CTRL_ADDR, 8'h09);
		for (int i = 0; i < 6; i++)
		begin
			low_run(i == 0 ? 37 : 1 + rnd() % 36);
			tick(2);
			chk("flag after dip", {7'h00, flag}, 8'h00);
		end
		amv = 16'h0A00;
		tick(50);
		chk("flag set", {6'h00, flag, irq}, 8'h02);
		irq_en = 1'b1;
		wr(PSM_CTRL_ADDR, 8'h09);
		chk("blocked clear", {6'h00, flag, irq}, 8'h03);
		amv = 16'h0D00;
		tick(TMO / 2);
		low_run(45);
		tick(TMO - 4);
		chk("flag in timeout", {7'h00, flag}, 8'h01);
		tick(12);
		chk("flag timed out", {6'h00, flag, irq}, 8'h00);
		low_run(45);
		tick(3);
		wr(PSM_CTRL_ADDR, 8'h09);
		chk("software clear", {7'h00, flag}, 8'h00);
		wr(PSM_CTRL_ADDR, 8'h08);
		low_run(50);
		chk("disabled", {7'h00, flag}, 8'h00);
		ce = 1'b0;
		wr(PSM_CTRL_ADDR, 8'h19);
		chk("frozen", {5'h00, trip, en}, 8'h02);
		give_verdict();
	end
endmodule

`default_nettype wire
